// ---- hw/scsi_pkg.sv ----
`default_nettype none
package scsi_pkg;

  // register byte offsets
  localparam logic [4:0] SCSI_OFS_CTRL = 5'h00;
  localparam logic [4:0] SCSI_OFS_SIG = 5'h04;
  localparam logic [4:0] SCSI_OFS_STATE = 5'h08;
  localparam logic [4:0] SCSI_OFS_IRQ_STAT = 5'h0c;
  localparam logic [4:0] SCSI_OFS_IRQ_MASK = 5'h10;

  // operating mode codes held in the control register
  localparam logic [1:0] SCSI_MODE_INIT = 2'h0;
  localparam logic [1:0] SCSI_MODE_PROGRAM = 2'h1;
  localparam logic [1:0] SCSI_MODE_RUN = 2'h2;
  localparam logic [1:0] SCSI_MODE_DEBUG = 2'h3;

  // interrupt event bit positions
  localparam int SCSI_EV_STOP_ERR = 0;
  localparam int SCSI_EV_FATAL = 1;
  localparam int SCSI_EV_CONN_UP = 2;
  localparam int SCSI_EV_BITS = 3;

  // reset values
  localparam logic [8:0] SCSI_CTRL_RESET = 9'h000;
  localparam logic [7:0] SCSI_SIG_RESET = 8'h00;
  localparam logic [2:0] SCSI_IRQ_RESET = 3'h0;

  // blink timing: half period in ms at a 100 ns clock
  localparam longint SCSI_BLINK_HALF_MS = 1000;
  localparam longint SCSI_CLK_PERIOD_NS = 100;
  localparam longint SCSI_BLINK_CYCLES = SCSI_BLINK_HALF_MS * 64'd1000000 / SCSI_CLK_PERIOD_NS;

  // segment patterns, bit order g f e d c b a, active high
  localparam logic [6:0] SCSI_SEG_DASH = 7'h40;
  localparam logic [6:0] SCSI_SEG_BLANK = 7'h00;

  // control word written by the safety firmware
  typedef struct packed {
    logic conn_pending; // originator connections still opening
    logic sig_ok;       // signature confirmed
    logic valid_stored; // validated data in non-volatile memory
    logic local_err;    // local program error, program keeps going
    logic stop_err;     // program error that stopped everything
    logic fatal;        // fatal fault
    logic debug_run;    // program running while in debug mode
    logic [1:0] mode;   // operating mode code
  } scsi_ctrl_type;

  typedef struct packed {
    logic err_red;
    logic run_green;
    logic debug_yellow;
    logic valid_yellow;
  } scsi_leds_type;

  typedef struct packed {
    logic [6:0] hi;
    logic [6:0] lo;
  } scsi_digits_type;

  typedef enum logic [1:0] {
    SCSI_ST_INIT = 2'b01,
    SCSI_ST_READY = 2'b10
  } scsi_run_state_type;

  // hex digit to segments
  function automatic logic [6:0] scsi_hex7(input logic [3:0] v);
    case (v)
      4'h0: scsi_hex7 = 7'h3f;
      4'h1: scsi_hex7 = 7'h06;
      4'h2: scsi_hex7 = 7'h5b;
      4'h3: scsi_hex7 = 7'h4f;
      4'h4: scsi_hex7 = 7'h66;
      4'h5: scsi_hex7 = 7'h6d;
      4'h6: scsi_hex7 = 7'h7d;
      4'h7: scsi_hex7 = 7'h07;
      4'h8: scsi_hex7 = 7'h7f;
      4'h9: scsi_hex7 = 7'h6f;
      4'ha: scsi_hex7 = 7'h77;
      4'hb: scsi_hex7 = 7'h7c;
      4'hc: scsi_hex7 = 7'h39;
      4'hd: scsi_hex7 = 7'h5e;
      4'he: scsi_hex7 = 7'h79;
      default: scsi_hex7 = 7'h71;
    endcase
  endfunction

endpackage
`default_nettype wire

// ---- hw/scsi_indicators.sv ----
`default_nettype none
module scsi_indicators
  import scsi_pkg::*;
#(
  parameter longint BLINK_CYCLES = SCSI_BLINK_CYCLES
)(
  input wire logic sys_clk,                // 10 MHz system clock
  input wire logic nrst,                   // async reset, active low
  input wire logic [4:0] avs_address,      // byte address
  input wire logic avs_read,               // read request
  input wire logic avs_write,              // write request
  input wire logic [31:0] avs_writedata,   // write data
  input wire logic [3:0] avs_byteenable,   // byte lanes
  output logic [31:0] avs_readdata,        // read data, registered
  output logic avs_waitrequest,            // stall until answer
  output logic irq,                        // level interrupt
  output scsi_leds_type leds,              // four front lamps
  output scsi_digits_type digits           // two seven-segment digits
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops

  logic rst_meta;
  logic rst_n;

  // async assert, sync release so every flop leaves reset on one edge
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [23:0] blink_cnt;
    logic blink;
    scsi_run_state_type run_st;
    scsi_ctrl_type ctrl;
    logic [7:0] sig;
    logic [SCSI_EV_BITS-1:0] irq_stat;
    logic [SCSI_EV_BITS-1:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
    scsi_leds_type leds;
    scsi_digits_type digits;
  } scsi_state_type;

  scsi_state_type s;
  scsi_state_type next_s;

  // merge write data into an old word under byte enables
  function automatic logic [31:0] scsi_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [31:0] w;
    logic stb;
    logic [SCSI_EV_BITS-1:0] ev;
    logic [SCSI_EV_BITS-1:0] clr;
    scsi_ctrl_type c;
    logic dig_on;
    w = 32'h0;
    stb = 1'b0;
    ev = '0;
    clr = '0;
    c = s.ctrl;
    dig_on = 1'b0;
    next_s = s;

    // shared 1 s on / 1 s off divider
    if (s.blink_cnt == 24'(BLINK_CYCLES - 1))
    begin
      next_s.blink_cnt = 24'h0;
      next_s.blink = ~s.blink;
    end
    else
    begin
      next_s.blink_cnt = s.blink_cnt + 24'h1;
    end

    // bus slave: one wait cycle, answer on the second edge
    stb = (avs_read | avs_write) & ~s.ack;
    next_s.ack = stb;
    if (stb && avs_read)
    begin
      case (avs_address)
        SCSI_OFS_CTRL: next_s.rdata = {23'h0, s.ctrl};
        SCSI_OFS_SIG: next_s.rdata = {24'h0, s.sig};
        SCSI_OFS_STATE: next_s.rdata = {25'h0, s.run_st, s.blink, s.leds};
        SCSI_OFS_IRQ_STAT: next_s.rdata = {29'h0, s.irq_stat};
        SCSI_OFS_IRQ_MASK: next_s.rdata = {29'h0, s.irq_mask};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (stb && avs_write)
    begin
      case (avs_address)
        SCSI_OFS_CTRL:
        begin
          w = scsi_merge({23'h0, s.ctrl}, avs_writedata, avs_byteenable);
          c = w[8:0];
        end
        SCSI_OFS_SIG:
        begin
          w = scsi_merge({24'h0, s.sig}, avs_writedata, avs_byteenable);
          next_s.sig = w[7:0];
        end
        SCSI_OFS_IRQ_STAT:
        begin
          if (avs_byteenable[0])
          begin
            clr = avs_writedata[SCSI_EV_BITS-1:0];
          end
        end
        SCSI_OFS_IRQ_MASK:
        begin
          if (avs_byteenable[0])
          begin
            next_s.irq_mask = avs_writedata[SCSI_EV_BITS-1:0];
          end
        end
        default: next_s.irq_mask = s.irq_mask;
      endcase
    end
    next_s.ctrl = c;

    // events from control changes; a set in the clearing cycle wins
    ev[SCSI_EV_STOP_ERR] = c.stop_err & ~s.ctrl.stop_err;
    ev[SCSI_EV_FATAL] = c.fatal & ~s.ctrl.fatal;
    ev[SCSI_EV_CONN_UP] = ~c.conn_pending & s.ctrl.conn_pending;
    next_s.irq_stat = (s.irq_stat & ~clr) | ev;

    // init phase ends once RUN or PROGRAM is reached, never returns
    case (s.run_st)
      SCSI_ST_INIT:
      begin
        if (c.mode == SCSI_MODE_RUN || c.mode == SCSI_MODE_PROGRAM)
        begin
          next_s.run_st = SCSI_ST_READY;
        end
      end
      SCSI_ST_READY: next_s.run_st = SCSI_ST_READY;
      default: next_s.run_st = SCSI_ST_INIT;
    endcase

    // red program error lamp, stop error ahead of local error
    if (c.stop_err)
    begin
      next_s.leds.err_red = 1'b1;
    end
    else if (c.local_err)
    begin
      next_s.leds.err_red = next_s.blink;
    end
    else
    begin
      next_s.leds.err_red = 1'b0;
    end

    // green run lamp
    if (c.fatal)
    begin
      next_s.leds.run_green = 1'b0;
    end
    else if (next_s.run_st == SCSI_ST_INIT)
    begin
      next_s.leds.run_green = next_s.blink;
    end
    else
    begin
      next_s.leds.run_green = (c.mode == SCSI_MODE_RUN) ||
                              (c.mode == SCSI_MODE_DEBUG && c.debug_run);
    end

    // yellow lamps; a fatal fault kills both
    next_s.leds.debug_yellow = (c.mode == SCSI_MODE_DEBUG) & ~c.fatal;
    next_s.leds.valid_yellow = c.valid_stored & ~c.fatal;

    // digits go dark in the off phase while connections are pending
    dig_on = ~c.conn_pending | next_s.blink;
    if (!dig_on)
    begin
      next_s.digits = {SCSI_SEG_BLANK, SCSI_SEG_BLANK};
    end
    else if (!c.sig_ok)
    begin
      next_s.digits = {SCSI_SEG_DASH, SCSI_SEG_DASH};
    end
    else
    begin
      next_s.digits = {scsi_hex7(next_s.sig[7:4]), scsi_hex7(next_s.sig[3:0])};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // all lamps and digits come up dark from reset
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s.blink_cnt <= 24'h0;
      s.blink <= 1'b0;
      s.run_st <= SCSI_ST_INIT;
      s.ctrl <= SCSI_CTRL_RESET;
      s.sig <= SCSI_SIG_RESET;
      s.irq_stat <= SCSI_IRQ_RESET;
      s.irq_mask <= SCSI_IRQ_RESET;
      s.ack <= 1'b0;
      s.rdata <= 32'h0;
      s.leds <= '0;
      s.digits <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // waitrequest is combinational so a request is held exactly one extra cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~s.ack;
  assign avs_readdata = s.rdata;
  assign irq = |(s.irq_stat & s.irq_mask);
  assign leds = s.leds;
  assign digits = s.digits;

endmodule
`default_nettype wire

// ---- dv/scsi_props.sv ----
`default_nettype none
module scsi_props
  import scsi_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic nrst, // reset, active low
  input wire logic [4:0] avs_address, // address
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [31:0] avs_writedata, // write data
  input wire logic avs_waitrequest, // stall
  input wire logic irq, // interrupt
  input wire scsi_leds_type leds, // lamps
  input wire scsi_digits_type digits // digits
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] c;
  logic [2:0] age;
  logic ok;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // shadow control word; age skips the internal reset lag
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      c <= 9'h000;
      age <= 3'h0;
    end
    else
    begin
      if (avs_write && !avs_waitrequest && avs_address == SCSI_OFS_CTRL) c <= avs_writedata[8:0];
      if (age != 3'h7) age <= age + 3'h1;
    end
  // lamps move a cycle before the shadow, so the write cycle is skipped
  assign ok = age == 3'h7 && !(avs_write && avs_address == SCSI_OFS_CTRL);
  ////////////////////////////////////////////////////////////////////
  property p_err_on; ok && c[4] |-> leds.err_red; endproperty
  a_err_on: assert property (p_err_on) else $error("red lamp dark");
  property p_err_off; ok && !c[4] && !c[5] |-> !leds.err_red; endproperty
  a_err_off: assert property (p_err_off) else $error("red lamp lit");
  property p_run_on; ok && c[1:0] == 2'h2 && !c[3] |-> leds.run_green; endproperty
  a_run_on: assert property (p_run_on) else $error("run lamp dark");
  property p_run_off; ok && (c[3] || c[1:0] == 2'h1) |-> !leds.run_green; endproperty
  a_run_off: assert property (p_run_off) else $error("run lamp lit");
  property p_dbg; ok |-> leds.debug_yellow == (c[1:0] == 2'h3 && !c[3]); endproperty
  a_dbg: assert property (p_dbg) else $error("debug lamp wrong");
  property p_val; ok |-> leds.valid_yellow == (c[6] && !c[3]); endproperty
  a_val: assert property (p_val) else $error("valid lamp wrong");
  property p_dash; ok && !c[7] |-> digits == {SCSI_SEG_DASH, SCSI_SEG_DASH} || c[8]
    && digits == 14'h0; endproperty
  a_dash: assert property (p_dash) else $error("dashes missing");
  property p_rst; $rose(nrst) |-> leds == 4'h0 && digits == 14'h0 && !irq; endproperty
  a_rst: assert property (p_rst) else $error("outputs live at reset");
  property p_wait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("read answer late");
  // covers for the main scenarios
  c_local: cover property (ok && c[5] && !c[4] && leds.err_red);
  c_conn: cover property (ok && c[8] && digits == 14'h0);
  c_irq: cover property (irq);
endmodule
`default_nettype wire

// ---- dv/scsi_panel.sv ----
`default_nettype none
module scsi_panel
  import scsi_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic clear, // start a new look
  input wire scsi_leds_type leds, // lamps
  input wire scsi_digits_type digits, // digits
  output logic [17:0] lit_any, // ever lit
  output logic [17:0] lit_all // never dark
);
  timeunit 1ns;
  timeprecision 1ns;
  // the operator's eye: a blinking segment shows up in any but not in all
  always_ff @(posedge sys_clk)
    if (clear)
    begin
      lit_any <= {leds, digits};
      lit_all <= {leds, digits};
    end
    else
    begin
      lit_any <= lit_any | {leds, digits};
      lit_all <= lit_all & {leds, digits};
    end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`default_nettype none
module tb_top
  import scsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BLINK = 8;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic clear = 1'b0;
  scsi_leds_type leds;
  scsi_digits_type digits;
  logic [17:0] lit_any;
  logic [17:0] lit_all;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  logic init_on = 1'b1;
  logic [8:0] ctrl = 9'h000;
  logic [7:0] sig = 8'h00;
  logic [31:0] rd;
  logic [6:0] font [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
    7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
  logic [8:0] corner [5] = '{9'h007, 9'h030, 9'h106, 9'h08f, 9'h0c1};
  scsi_indicators #(.BLINK_CYCLES(BLINK)) DUT (.sys_clk, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .irq,
    .leds, .digits);
  scsi_panel u_panel (.sys_clk, .clear, .leds, .digits, .lit_any, .lit_all);
  always #50 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      fails = fails + 1;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one bus cycle; waitrequest looked at mid-cycle, so it is settled; the wait has
  // no cap of its own, only the hang guard ends a stuck request
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(negedge sys_clk); while (avs_waitrequest);
    @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wrctrl(input logic [8:0] c);
    ctrl = c;
    if (c[1:0] == SCSI_MODE_RUN || c[1:0] == SCSI_MODE_PROGRAM) init_on = 1'b0;
    bus(1'b1, SCSI_OFS_CTRL, {23'h0, c});
  endtask
  // expected look of lamp i, red first: 0 dark, 1 steady, 2 blinking
  function automatic int lamp_code(input int i);
    logic [1:0] m;
    m = ctrl[1:0];
    case (i)
      0: return ctrl[4] ? 1 : ctrl[5] ? 2 : 0;
      1: return ctrl[3] ? 0 : init_on ? 2 :
        (m == SCSI_MODE_RUN || m == SCSI_MODE_DEBUG && ctrl[2]) ? 1 : 0;
      2: return (m == SCSI_MODE_DEBUG && !ctrl[3]) ? 1 : 0;
      default: return (ctrl[6] && !ctrl[3]) ? 1 : 0;
    endcase
  endfunction
  // expected digit pattern in the lit phase
  function automatic logic [13:0] exp_seg();
    return ctrl[7] ? {font[sig[7:4]], font[sig[3:0]]} : {SCSI_SEG_DASH, SCSI_SEG_DASH};
  endfunction
  // watch one blink period plus two cycles and hold the panel against the expected looks
  task automatic watch();
    logic [3:0] ea;
    logic [3:0] el;
    logic [13:0] seg;
    for (int i = 0; i < 4; i++)
    begin
      ea[3 - i] = lamp_code(i) != 0;
      el[3 - i] = lamp_code(i) == 1;
    end
    seg = exp_seg();
    clear <= 1'b1;
    @(posedge sys_clk);
    clear <= 1'b0;
    repeat (2 * BLINK + 2) @(posedge sys_clk);
    @(negedge sys_clk);
    check("lamps ever lit", lit_any[17:14], ea);
    check("lamps steady", lit_all[17:14], el);
    check("digits ever lit", lit_any[13:0], seg);
    check("digits steady", lit_all[13:0], ctrl[8] ? 14'h0 : seg);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    void'($urandom(32'he1a4));
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    wait (leds.run_green);
    n = 0;
    do @(negedge sys_clk); while (leds.run_green && ++n < 100);
    check("blink half period", n, BLINK);
    watch();
    bus(1'b0, SCSI_OFS_STATE, 32'h0);
    check("run state", rd[6:5], SCSI_ST_INIT);
    $display("test init done");
    bus(1'b1, SCSI_OFS_IRQ_MASK, 32'h7);
    wrctrl(9'h118);
    bus(1'b0, SCSI_OFS_IRQ_STAT, 32'h0);
    check("irq status", rd, 32'h3);
    check("irq line", irq, 1'b1);
    wrctrl(9'h000);
    bus(1'b0, SCSI_OFS_IRQ_STAT, 32'h0);
    check("irq status", rd, 32'h7);
    bus(1'b1, SCSI_OFS_IRQ_MASK, 32'h0);
    repeat (2) @(negedge sys_clk);
    check("irq masked", irq, 1'b0);
    bus(1'b1, SCSI_OFS_IRQ_MASK, 32'h7);
    bus(1'b1, SCSI_OFS_IRQ_STAT, 32'h7);
    repeat (2) @(negedge sys_clk);
    check("irq cleared", irq, 1'b0);
    bus(1'b1, 5'h14, 32'hffff);
    bus(1'b0, 5'h14, 32'h0);
    check("unmapped read", rd, 32'h0);
    $display("test irq done");
    // corner words first, then random words with random signatures
    for (int i = 0; i < 30; i++)
    begin
      sig = 8'($urandom);
      bus(1'b1, SCSI_OFS_SIG, {24'h0, sig});
      wrctrl(i < 5 ? corner[i] : 9'($urandom));
      bus(1'b0, SCSI_OFS_CTRL, 32'h0);
      check("control readback", rd, {23'h0, ctrl});
      bus(1'b0, SCSI_OFS_SIG, 32'h0);
      check("signature readback", rd, {24'h0, sig});
      watch();
    end
    bus(1'b0, SCSI_OFS_STATE, 32'h0);
    check("run state", rd[6:5], SCSI_ST_READY);
    $display("test random done");
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check("lamps in reset", leds, 4'h0);
    check("digits in reset", digits, 14'h0);
    // second release: indication restarts from the reset control word
    @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(negedge sys_clk);
    check("lamps after reset", leds, 4'h0);
    check("digits after reset", digits, {SCSI_SEG_DASH, SCSI_SEG_DASH});
    $display("test reset done");
    close_out();
  end
endmodule
bind scsi_indicators scsi_props u_props (.sys_clk, .nrst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_waitrequest, .irq, .leds, .digits);
`default_nettype wire
